// ### rtl/mmd_cfg.svh
`ifndef MMD_CFG_SVH
`define MMD_CFG_SVH
// ----------------------------------------------------------------------
// program space
// ----------------------------------------------------------------------
`define MMD_CRAM_END      16'h1800
`define MMD_ROM_LO_PAGE   3'h0
`define MMD_ROM_HI_PAGE   3'h4
// ----------------------------------------------------------------------
// external data space
// ----------------------------------------------------------------------
`define MMD_WIN_PAGE      5'h1F
`define MMD_BUF_LO        16'hFA10
`define MMD_SETUP_LO      16'hFF28
`define MMD_CFG_LO        16'hFF30
`define MMD_MMR_LO        16'hFFB0
`define MMD_XBUF_BASE     16'hF800
`define MMD_RESET_MODE    1'h0
// ----------------------------------------------------------------------
// configuration block byte offsets
// ----------------------------------------------------------------------
`define MMD_OFS_CNF       3'h0
`define MMD_OFS_BBAX      3'h1
`define MMD_OFS_BSIZ      3'h2
`define MMD_OFS_DCNTX     3'h3
`define MMD_OFS_BBAY      3'h5
`define MMD_OFS_DCNTY     3'h7
`define MMD_CNF_ISO_BIT   6
// ----------------------------------------------------------------------
// internal data space
// ----------------------------------------------------------------------
`define MMD_SPECIAL_LO    8'h80
`endif

// ### rtl/mmd_pkg.sv
package mmd_pkg;
  typedef enum logic [0:0] {MMD_BOOT = 1'b0, MMD_NORMAL = 1'b1} mmd_mode_t;
  typedef enum logic [1:0] {MMD_P_NONE = 2'b00, MMD_P_ROM = 2'b01,
                            MMD_P_CRAM = 2'b10} mmd_preg_t;
  typedef enum logic [2:0] {MMD_X_NONE = 3'b000, MMD_X_CODE = 3'b001,
                            MMD_X_BUF = 3'b010, MMD_X_CFG = 3'b011,
                            MMD_X_SETUP = 3'b100, MMD_X_MMR = 3'b101} mmd_xreg_t;
  typedef enum logic [1:0] {MMD_I_NONE = 2'b00, MMD_I_LOW = 2'b01,
                            MMD_I_SPECIAL = 2'b10} mmd_ireg_t;
  typedef struct packed {
    mmd_preg_t   region;
    logic [12:0] offset;
  } mmd_psel_t;
  typedef struct packed {
    logic        req;
    logic        we;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } mmd_xreq_t;
  typedef struct packed {
    mmd_xreg_t   region;
    logic [12:0] offset;
    logic        wr_en;
  } mmd_xsel_t;
  typedef struct packed {
    logic       we;
    logic [2:0] ep;
    logic       y;
    logic [7:0] cnt;
  } mmd_cntwr_t;
  typedef struct packed {
    logic [15:0] start;
    logic [7:0]  len;
    logic [7:0]  count;
    logic        iso;
  } mmd_look_t;
endpackage

// ### rtl/mmd_decoder.sv
`include "mmd_cfg.svh"
module mmd_decoder
(
  // clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 rst_n,
  // mode control
  input  wire logic                 code_ram_select_set,
  input  wire logic                 ext_mcu_mode,
  output mmd_pkg::mmd_mode_t        mode_r,
  // program space fetch
  input  wire logic                 pf_req,
  input  wire logic [15:0]          pf_addr,
  output mmd_pkg::mmd_psel_t        pf_sel_r,
  // external data space
  input  mmd_pkg::mmd_xreq_t        xd_req,
  output mmd_pkg::mmd_xsel_t        xd_sel_r,
  output logic                      xd_ack_r,
  output logic [7:0]                xd_rdata_r,
  // internal data space
  input  wire logic                 id_req,
  input  wire logic                 id_indirect,
  input  wire logic [7:0]           id_addr,
  output mmd_pkg::mmd_ireg_t        id_sel_r,
  output logic [6:0]                id_offset_r,
  // data count writers
  input  mmd_pkg::mmd_cntwr_t       usb_buffer_manager_wr,
  input  mmd_pkg::mmd_cntwr_t       dma_wr,
  // buffer lookup
  input  wire logic                 lk_req,
  input  wire logic                 lk_out,
  input  wire logic [2:0]           lk_ep,
  input  wire logic                 lk_y,
  output mmd_pkg::mmd_look_t        lk_r
);
  import mmd_pkg::*;

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  // block index: OUT blocks sit in the upper half, endpoint 0 at the top
  function automatic logic [3:0] ep_blk(input logic is_out, input logic [2:0] ep);
    ep_blk = {is_out, ~ep};
  endfunction

  // byte index of the X or Y data count of a block
  function automatic logic [6:0] cnt_idx(input logic [3:0] blk, input logic y);
    cnt_idx = {blk, (y ? `MMD_OFS_DCNTY : `MMD_OFS_DCNTX)};
  endfunction

  // region decode of a full 16-bit data address
  function automatic mmd_xreg_t x_region(input logic [15:0] a, input mmd_mode_t m,
                                         input logic ext);
    if (a >= `MMD_MMR_LO)
      x_region = MMD_X_MMR;
    else if (a >= `MMD_CFG_LO)
      x_region = MMD_X_CFG;
    else if (a >= `MMD_SETUP_LO)
      x_region = ext ? MMD_X_NONE : MMD_X_SETUP;
    else if (a >= `MMD_BUF_LO)
      x_region = MMD_X_BUF;
    else if (!ext && m == MMD_BOOT && a < `MMD_CRAM_END)
      x_region = MMD_X_CODE;
    else
      x_region = MMD_X_NONE;
  endfunction

  // ----------------------------------------------------------------------
  // operating mode
  // ----------------------------------------------------------------------
  mmd_mode_t mode_nxt;

  // only a master reset returns to the boot loader mapping
  always_comb
  begin
    case (mode_r)
      MMD_BOOT:   mode_nxt = code_ram_select_set ? MMD_NORMAL : MMD_BOOT;
      MMD_NORMAL: mode_nxt = MMD_NORMAL;
      default:    mode_nxt = MMD_BOOT;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      mode_r <= mmd_mode_t'(`MMD_RESET_MODE);
    else
      mode_r <= mode_nxt;
  end

  // ----------------------------------------------------------------------
  // program space decode
  // ----------------------------------------------------------------------
  mmd_psel_t pf_sel_nxt;

  // rom mirrored at both pages in boot mode, upper page only later; no rom at all with ext_mcu_mode
  always_comb
  begin
    pf_sel_nxt = '0;
    if (pf_req && !ext_mcu_mode)
    begin
      pf_sel_nxt.offset = pf_addr[12:0];
      if (pf_addr[15:13] == `MMD_ROM_HI_PAGE)
        pf_sel_nxt.region = MMD_P_ROM;
      else if (mode_r == MMD_BOOT && pf_addr[15:13] == `MMD_ROM_LO_PAGE)
        pf_sel_nxt.region = MMD_P_ROM;
      else if (mode_r == MMD_NORMAL && pf_addr < `MMD_CRAM_END)
        pf_sel_nxt.region = MMD_P_CRAM;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      pf_sel_r <= '0;
    else
      pf_sel_r <= pf_sel_nxt;
  end

  // ----------------------------------------------------------------------
  // external data space decode
  // ----------------------------------------------------------------------
  logic [15:0] xd_eff;
  mmd_xsel_t   xd_sel_nxt;
  logic        xd_ack_nxt;
  logic [7:0]  xd_rdata_nxt;
  logic [7:0]  cfg_r [0:127];
  logic [7:0]  cfg_nxt [0:127];

  // external controller only drives A0-A10: window mirrors every 2K
  assign xd_eff = ext_mcu_mode ? {`MMD_WIN_PAGE, xd_req.addr[10:0]} : xd_req.addr;

  // every access is acknowledged, code ram writes in normal mode dropped
  always_comb
  begin
    xd_sel_nxt   = '0;
    xd_rdata_nxt = 8'h00;
    xd_ack_nxt   = xd_req.req;
    if (xd_req.req)
    begin
      xd_sel_nxt.region = x_region(xd_eff, mode_r, ext_mcu_mode);
      xd_sel_nxt.offset = (xd_sel_nxt.region == MMD_X_CODE) ? xd_eff[12:0]
                                                             : {2'b00, xd_eff[10:0]};
      xd_sel_nxt.wr_en  = xd_req.we && (xd_sel_nxt.region != MMD_X_NONE);
      if (xd_sel_nxt.region == MMD_X_CFG)
        xd_rdata_nxt = cfg_r[7'(xd_eff - `MMD_CFG_LO)];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      xd_sel_r   <= '0;
      xd_ack_r   <= 1'b0;
      xd_rdata_r <= 8'h00;
    end
    else
    begin
      xd_sel_r   <= xd_sel_nxt;
      xd_ack_r   <= xd_ack_nxt;
      xd_rdata_r <= xd_rdata_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // internal data space decode
  // ----------------------------------------------------------------------
  mmd_ireg_t  id_sel_nxt;
  logic [6:0] id_offset_nxt;

  // lower half any mode, upper half direct only
  always_comb
  begin
    id_sel_nxt    = MMD_I_NONE;
    id_offset_nxt = id_addr[6:0];
    if (id_req)
    begin
      if (id_addr < `MMD_SPECIAL_LO)
        id_sel_nxt = MMD_I_LOW;
      else if (!id_indirect)
        id_sel_nxt = MMD_I_SPECIAL;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      id_sel_r    <= MMD_I_NONE;
      id_offset_r <= 7'h00;
    end
    else
    begin
      id_sel_r    <= id_sel_nxt;
      id_offset_r <= id_offset_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // endpoint configuration blocks
  // ----------------------------------------------------------------------
  logic [6:0] mcu_idx;
  logic       mcu_cfg_we;
  logic [6:0] bufmgr_idx;
  logic [6:0] dma_idx;

  assign mcu_idx    = 7'(xd_eff - `MMD_CFG_LO);
  assign mcu_cfg_we = xd_req.req && xd_req.we
                      && x_region(xd_eff, mode_r, ext_mcu_mode) == MMD_X_CFG;
  assign bufmgr_idx = cnt_idx(ep_blk(1'b0, usb_buffer_manager_wr.ep),
                              usb_buffer_manager_wr.y);
  assign dma_idx    = cnt_idx(ep_blk(1'b1, dma_wr.ep), dma_wr.y);

  // per byte: controller wins over buffer manager, which wins over dma
  genvar gi;
  generate
    for (gi = 0; gi < 128; gi++)
    begin : g_cfg
      always_comb
      begin
        if (mcu_cfg_we && mcu_idx == 7'(gi))
          cfg_nxt[gi] = xd_req.wdata;
        else if (usb_buffer_manager_wr.we && bufmgr_idx == 7'(gi))
          cfg_nxt[gi] = usb_buffer_manager_wr.cnt;
        else if (dma_wr.we && dma_idx == 7'(gi))
          cfg_nxt[gi] = dma_wr.cnt;
        else
          cfg_nxt[gi] = cfg_r[gi];
      end
    end
  endgenerate

  // sixteen blocks of eight bytes in flip-flops
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < 128; i++)
        cfg_r[i] <= 8'h00;
    end
    else
    begin
      for (int i = 0; i < 128; i++)
        cfg_r[i] <= cfg_nxt[i];
    end
  end

  // ----------------------------------------------------------------------
  // buffer lookup
  // ----------------------------------------------------------------------
  logic [3:0] lk_blk;
  logic       lk_iso;
  logic [7:0] lk_base;
  mmd_look_t  lk_nxt;

  assign lk_blk  = ep_blk(lk_out, lk_ep);
  assign lk_iso  = cfg_r[{lk_blk, `MMD_OFS_CNF}][`MMD_CNF_ISO_BIT];
  // isochronous endpoints run one circular buffer from the X base
  assign lk_base = (lk_y && !lk_iso) ? cfg_r[{lk_blk, `MMD_OFS_BBAY}]
                                     : cfg_r[{lk_blk, `MMD_OFS_BBAX}];

  // start address in eight-byte steps above the family base
  always_comb
  begin
    lk_nxt = lk_r;
    if (lk_req)
    begin
      lk_nxt.start = `MMD_XBUF_BASE + {5'h00, lk_base, 3'b000};
      lk_nxt.len   = cfg_r[{lk_blk, `MMD_OFS_BSIZ}];
      lk_nxt.count = cfg_r[cnt_idx(lk_blk, lk_y && !lk_iso)];
      lk_nxt.iso   = lk_iso;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      lk_r <= '0;
    else
      lk_r <= lk_nxt;
  end

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  property p_mode_hold;
    (mode_r == MMD_BOOT && !code_ram_select_set) |=> (mode_r == MMD_BOOT);
  endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("boot mode left");

  property p_rom_low;
    (mode_r == MMD_BOOT && pf_req && !ext_mcu_mode && pf_addr[15:13] == 3'h0)
      |=> (pf_sel_r.region == MMD_P_ROM && pf_sel_r.offset == $past(pf_addr[12:0]));
  endproperty
  a_rom_low: assert property (p_rom_low) else $error("rom not at 0000h");

  property p_cram_wr;
    (mode_r == MMD_BOOT && xd_req.req && xd_req.we && !ext_mcu_mode
     && xd_req.addr < 16'h1800) |=> (xd_sel_r.region == MMD_X_CODE && xd_sel_r.wr_en);
  endproperty
  a_cram_wr: assert property (p_cram_wr) else $error("code ram not writable");

  property p_cram_fetch;
    (mode_r == MMD_NORMAL && pf_req && !ext_mcu_mode && pf_addr < 16'h1800)
      ##1 (mode_r == MMD_NORMAL) |-> (pf_sel_r.region == MMD_P_CRAM);
  endproperty
  a_cram_fetch: assert property (p_cram_fetch) else $error("code ram not fetched");

  property p_cram_ro;
    (mode_r == MMD_NORMAL && xd_req.req && !ext_mcu_mode && xd_req.addr < 16'h1800)
      |=> (xd_ack_r && !xd_sel_r.wr_en && xd_sel_r.region != MMD_X_CODE);
  endproperty
  a_cram_ro: assert property (p_cram_ro) else $error("code ram written");

  property p_special_direct;
    (id_req && id_indirect && id_addr[7]) |=> (id_sel_r == MMD_I_NONE);
  endproperty
  a_special_direct: assert property (p_special_direct) else $error("indirect special hit");

  property p_ext_only;
    (ext_mcu_mode && xd_req.req) |=> (xd_sel_r.region != MMD_X_CODE
                                      && xd_sel_r.region != MMD_X_SETUP);
  endproperty
  a_ext_only: assert property (p_ext_only) else $error("ext region leak");

  property p_ext_mirror;
    (ext_mcu_mode && xd_req.req) |=> (xd_sel_r.offset[10:0] == $past(xd_req.addr[10:0]));
  endproperty
  a_ext_mirror: assert property (p_ext_mirror) else $error("ext mirror wrong");

  property p_align;
    lk_req |=> (lk_r.start[2:0] == 3'b000 && lk_r.start >= 16'hF800);
  endproperty
  a_align: assert property (p_align) else $error("buffer not aligned");

  property p_bufmgr_cnt;
    (usb_buffer_manager_wr.we && !mcu_cfg_we)
      |=> (cfg_r[$past(bufmgr_idx)] == $past(usb_buffer_manager_wr.cnt));
  endproperty
  a_bufmgr_cnt: assert property (p_bufmgr_cnt) else $error("in count lost");

  property p_dma_cnt;
    (dma_wr.we && !mcu_cfg_we && !usb_buffer_manager_wr.we)
      |=> (cfg_r[$past(dma_idx)] == $past(dma_wr.cnt));
  endproperty
  a_dma_cnt: assert property (p_dma_cnt) else $error("out count lost");

  c_switch: cover property (mode_r == MMD_BOOT ##1 mode_r == MMD_NORMAL);
  c_ext:    cover property (ext_mcu_mode && xd_req.req ##1 xd_sel_r.region == MMD_X_CFG);
  c_iso:    cover property (lk_req ##1 lk_r.iso);
endmodule // mmd_decoder

// ### bench/mmd_mcu_model.sv
module mmd_mcu_model
(
  // clock
  input  wire logic          sys_clk,
  // byte bus towards the decoder
  output mmd_pkg::mmd_xreq_t xd_req,
  input  wire logic          xd_ack_r,
  input  wire logic [7:0]    xd_rdata_r
);
  timeunit 1ns;
  timeprecision 1ps;
  import mmd_pkg::*;
  // idle bus at time zero
  initial xd_req = '0;
  // one byte per call; every address is sent here, nothing else shares the space
  task automatic access(input logic we, input logic [15:0] a, input logic [7:0] d,
                        output logic [7:0] q);
    begin
      @(posedge sys_clk);
      #1;
      xd_req = '{1'b1, we, a, d};
      @(posedge sys_clk);
      #1;
      q = xd_rdata_r;
      // released lines show the inverse, not the old value
      xd_req = '{1'b0, ~we, ~a, ~d};
    end
  endtask
endmodule // mmd_mcu_model

// ### bench/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import mmd_pkg::*;
  logic        sys_clk = 1'b0;
  logic        rst_n;
  logic        code_ram_select_set;
  logic        ext_mcu_mode;
  mmd_mode_t   mode_r;
  logic        pf_req;
  logic [15:0] pf_addr;
  mmd_psel_t   pf_sel_r;
  mmd_xreq_t   xd_req;
  mmd_xsel_t   xd_sel_r;
  logic        xd_ack_r;
  logic [7:0]  xd_rdata_r;
  logic        id_req;
  logic        id_indirect;
  logic [7:0]  id_addr;
  mmd_ireg_t   id_sel_r;
  logic [6:0]  id_offset_r;
  mmd_cntwr_t  bufmgr_wr;
  mmd_cntwr_t  dma_wr;
  logic        lk_req;
  logic        lk_out;
  logic [2:0]  lk_ep;
  logic        lk_y;
  mmd_look_t   lk_r;
  logic [7:0]  q;
  int          err_total = 0;
  int          checked = 0;
  // design and bus partner
  mmd_decoder i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .code_ram_select_set(code_ram_select_set),
    .ext_mcu_mode(ext_mcu_mode), .mode_r(mode_r), .pf_req(pf_req), .pf_addr(pf_addr),
    .pf_sel_r(pf_sel_r), .xd_req(xd_req), .xd_sel_r(xd_sel_r), .xd_ack_r(xd_ack_r),
    .xd_rdata_r(xd_rdata_r), .id_req(id_req), .id_indirect(id_indirect), .id_addr(id_addr),
    .id_sel_r(id_sel_r), .id_offset_r(id_offset_r), .usb_buffer_manager_wr(bufmgr_wr),
    .dma_wr(dma_wr), .lk_req(lk_req), .lk_out(lk_out), .lk_ep(lk_ep), .lk_y(lk_y), .lk_r(lk_r));
  mmd_mcu_model i_mcu (.sys_clk(sys_clk), .xd_req(xd_req), .xd_ack_r(xd_ack_r),
    .xd_rdata_r(xd_rdata_r));
  // 100 MHz clock
  always #5 sys_clk = ~sys_clk;
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    begin
      checked++;
      if (seen !== exp)
      begin
        err_total++;
        $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  task automatic complete_run();
    begin
      $display("checks %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  task automatic do_reset(input logic e);
    begin
      rst_n = 1'b0;
      ext_mcu_mode = e;
      repeat (20) @(posedge sys_clk);
      #1;
      rst_n = 1'b1;
    end
  endtask
  task automatic fetch(input logic [15:0] a, input logic [1:0] r, input logic [12:0] o);
    begin
      @(posedge sys_clk);
      #1;
      pf_req = 1'b1;
      pf_addr = a;
      @(posedge sys_clk);
      #1;
      pf_req = 1'b0;
      pf_addr = ~a;
      chk("pf region", pf_sel_r.region, r);
      chk("pf offset", pf_sel_r.offset, o);
    end
  endtask
  task automatic xacc(input logic we, input logic [15:0] a, input logic [7:0] d,
                      input logic [2:0] r, input logic wr);
    begin
      i_mcu.access(we, a, d, q);
      chk("xd ack", xd_ack_r, 1'b1);
      chk("xd region", xd_sel_r.region, r);
      chk("xd wr_en", xd_sel_r.wr_en, wr);
    end
  endtask
  task automatic iacc(input logic ind, input logic [7:0] a, input logic [1:0] r,
                      input logic [6:0] o);
    begin
      @(posedge sys_clk);
      #1;
      id_req = 1'b1;
      id_indirect = ind;
      id_addr = a;
      @(posedge sys_clk);
      #1;
      id_req = 1'b0;
      id_addr = ~a;
      chk("id region", id_sel_r, r);
      chk("id offset", id_offset_r, o);
    end
  endtask
  task automatic cntwr(input logic dma, input logic [2:0] e, input logic y, input logic [7:0] c);
    begin
      @(posedge sys_clk);
      #1;
      if (dma)
        dma_wr = '{1'b1, e, y, c};
      else
        bufmgr_wr = '{1'b1, e, y, c};
      @(posedge sys_clk);
      #1;
      dma_wr.we = 1'b0;
      bufmgr_wr.we = 1'b0;
    end
  endtask
  task automatic look(input logic o, input logic [2:0] e, input logic y, input logic [15:0] s,
                      input logic [7:0] n, input logic [7:0] c, input logic iso);
    begin
      @(posedge sys_clk);
      #1;
      lk_req = 1'b1;
      lk_out = o;
      lk_ep = e;
      lk_y = y;
      @(posedge sys_clk);
      #1;
      lk_req = 1'b0;
      chk("lk start", lk_r.start, s);
      chk("lk len", lk_r.len, n);
      chk("lk count", lk_r.count, c);
      chk("lk iso", lk_r.iso, iso);
    end
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_boot();
    begin
      chk("mode", mode_r, MMD_BOOT);
      fetch(16'h0000, MMD_P_ROM, 13'h0000);
      fetch(16'h1FFF, MMD_P_ROM, 13'h1FFF);
      fetch(16'h8005, MMD_P_ROM, 13'h0005);
      fetch(16'h9FFF, MMD_P_ROM, 13'h1FFF);
      fetch(16'hA000, MMD_P_NONE, 13'h0000);
      xacc(1'b1, 16'h0100, 8'h5A, MMD_X_CODE, 1'b1);
      chk("xd offset", xd_sel_r.offset, 13'h0100);
      xacc(1'b1, 16'h17FF, 8'hA5, MMD_X_CODE, 1'b1);
      xacc(1'b1, 16'h1800, 8'hA5, MMD_X_NONE, 1'b0);
      iacc(1'b0, 8'h00, MMD_I_LOW, 7'h00);
      $display("test boot map done");
    end
  endtask
  task automatic t_normal();
    begin
      @(posedge sys_clk);
      #1;
      code_ram_select_set = 1'b1;
      @(posedge sys_clk);
      #1;
      code_ram_select_set = 1'b0;
      fetch(16'h0000, MMD_P_CRAM, 13'h0000);
      fetch(16'h17FF, MMD_P_CRAM, 13'h17FF);
      fetch(16'h1800, MMD_P_NONE, 13'h1800);
      fetch(16'h8010, MMD_P_ROM, 13'h0010);
      xacc(1'b1, 16'h0100, 8'h3C, MMD_X_NONE, 1'b0);
      chk("mode", mode_r, MMD_NORMAL);
      $display("test normal map done");
    end
  endtask
  task automatic t_data();
    logic [15:0] a [8];
    logic [2:0]  r [8];
    begin
      a = '{16'hFA10, 16'hFF27, 16'hFF28, 16'hFF2F, 16'hFFAF, 16'hFFB0, 16'hFFFF, 16'hFA0F};
      r = '{MMD_X_BUF, MMD_X_BUF, MMD_X_SETUP, MMD_X_SETUP, MMD_X_CFG, MMD_X_MMR, MMD_X_MMR,
            MMD_X_NONE};
      for (int i = 0; i < 8; i++)
        xacc(1'b0, a[i], 8'h00, r[i], 1'b0);
      iacc(1'b1, 8'h7F, MMD_I_LOW, 7'h7F);
      iacc(1'b0, 8'h80, MMD_I_SPECIAL, 7'h00);
      iacc(1'b0, 8'hFF, MMD_I_SPECIAL, 7'h7F);
      iacc(1'b1, 8'h80, MMD_I_NONE, 7'h00);
      $display("test data space done");
    end
  endtask
  task automatic t_cfg();
    begin
      xacc(1'b1, 16'hFF50, 8'h00, MMD_X_CFG, 1'b1);
      xacc(1'b1, 16'hFF51, 8'h4C, MMD_X_CFG, 1'b1);
      xacc(1'b1, 16'hFF52, 8'h40, MMD_X_CFG, 1'b1);
      xacc(1'b1, 16'hFF55, 8'h50, MMD_X_CFG, 1'b1);
      cntwr(1'b0, 3'h3, 1'b0, 8'h21);
      cntwr(1'b1, 3'h3, 1'b1, 8'h33);
      cntwr(1'b1, 3'h0, 1'b1, 8'h12);
      xacc(1'b0, 16'hFF53, 8'h00, MMD_X_CFG, 1'b0);
      chk("in ep3 count x", q, 8'h21);
      xacc(1'b0, 16'hFF97, 8'h00, MMD_X_CFG, 1'b0);
      chk("out ep3 count y", q, 8'h33);
      xacc(1'b0, 16'hFFAF, 8'h00, MMD_X_CFG, 1'b0);
      chk("out ep0 count y", q, 8'h12);
      look(1'b0, 3'h3, 1'b0, 16'hFA60, 8'h40, 8'h21, 1'b0);
      look(1'b0, 3'h3, 1'b1, 16'hFA80, 8'h40, 8'h00, 1'b0);
      xacc(1'b1, 16'hFF50, 8'h40, MMD_X_CFG, 1'b1);
      look(1'b0, 3'h3, 1'b1, 16'hFA60, 8'h40, 8'h21, 1'b1);
      $display("test config blocks done");
    end
  endtask
  task automatic t_ext();
    begin
      @(posedge sys_clk);
      #1;
      do_reset(1'b1);
      chk("mode", mode_r, MMD_BOOT);
      fetch(16'h0000, MMD_P_NONE, 13'h0000);
      xacc(1'b0, 16'h0FB0, 8'h00, MMD_X_MMR, 1'b0);
      chk("xd offset", xd_sel_r.offset, 13'h07B0);
      xacc(1'b0, 16'h7A10, 8'h00, MMD_X_BUF, 1'b0);
      xacc(1'b0, 16'h3F30, 8'h00, MMD_X_CFG, 1'b0);
      chk("cleared cfg", q, 8'h00);
      xacc(1'b0, 16'h0728, 8'h00, MMD_X_NONE, 1'b0);
      xacc(1'b1, 16'h0100, 8'h00, MMD_X_NONE, 1'b0);
      $display("test external controller done");
    end
  endtask
  // watchdog
  initial
  begin
    #200us;
    err_total++;
    complete_run();
  end
  // main sequence
  initial
  begin
    code_ram_select_set = 1'b0;
    pf_req = 1'b0;
    pf_addr = '0;
    id_req = 1'b0;
    id_indirect = 1'b0;
    id_addr = '0;
    bufmgr_wr = '0;
    dma_wr = '0;
    lk_req = 1'b0;
    lk_out = 1'b0;
    lk_ep = '0;
    lk_y = 1'b0;
    do_reset(1'b0);
    t_boot();
    t_normal();
    t_data();
    t_cfg();
    t_ext();
    complete_run();
  end
endmodule // tb
